// ===== shared/flash_protect_pkg.sv
// constants, field positions and opcodes of the array write-protect block
// assumes a 32MB array of 64KB blocks, addressed by byte
package flash_protect_pkg;

  // ------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------
  localparam int         ADDR_W       = 25;
  localparam int         BLK_W        = 9;
  localparam int         BLK_LSB      = 16;
  localparam int         SECT_W       = 4;
  localparam int         SECT_LSB     = 12;
  localparam int         SECT_PER_BLK = 16;
  localparam int         UNITS        = 542;
  localparam int         UNIT_W       = 10;
  localparam logic [8:0] BLK_FIRST    = 9'h000;
  localparam logic [8:0] BLK_LAST     = 9'h1ff;
  localparam logic [9:0] BLK_COUNT    = 10'h200;
  localparam logic [9:0] MID_UNIT_OFS = 10'h00f;
  localparam logic [9:0] TOP_UNIT_BASE = 10'h20e;

  // ------------------------------------------------------------
  // span code fields
  // ------------------------------------------------------------
  localparam int         SPAN_W       = 5;
  localparam int         SPAN_LOW_BIT = 4;
  localparam int         SPAN_B3      = 3;
  localparam int         SPAN_B2      = 2;
  localparam int         SPAN_B1      = 1;
  localparam logic [3:0] SPAN_NONE    = 4'h0;
  localparam logic [3:0] SPAN_ONE     = 4'h1;

  // ------------------------------------------------------------
  // mode select one-time-programmable register
  // ------------------------------------------------------------
  localparam int          LOCK_W        = 16;
  localparam int          LOCK_SOLID_BIT = 1;
  localparam int          LOCK_PASS_BIT  = 2;
  localparam logic [15:0] LOCK_DEFAULT  = 16'hffff;
  localparam logic [1:0]  LOCK_UNCHOSEN = 2'h3;
  localparam logic [1:0]  LOCK_BOTH_ZERO = 2'h0;
  localparam int          MASK_DATA_BIT = 0;

  // ------------------------------------------------------------
  // instructions seen by this block
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    op_prog, op_erase_sector, op_erase_block,
    op_pers_set, op_pers_erase_all,
    op_vol_set, op_vol_clear, op_vol_all_set, op_vol_all_clear,
    op_mask_write, op_lock_bit_clear, op_lock_reg_write
  } op_t;

endpackage : flash_protect_pkg

// ===== design/span_range_decode.sv
// span code and invert flag to a per-block protect decision
// assumes span code and flag are stable status bits on the same clock
`timescale 1ns/1ns
module span_range_decode (
  input  wire logic [4:0] span_code,        // span code bits 4..0
  input  wire logic       invert_span_flag, // complement the range
  input  wire logic [8:0] blk,              // 64KB block index
  output logic            hit               // block is protected
);
  logic [3:0] n;
  logic [9:0] cnt;
  logic       all_c;
  logic       none_c;
  logic       base_c;

  always_comb
  begin
    n      = span_code[3:0];
    all_c  = span_code[flash_protect_pkg::SPAN_B3] &
             (span_code[flash_protect_pkg::SPAN_B2] |
              span_code[flash_protect_pkg::SPAN_B1]);
    none_c = (n == flash_protect_pkg::SPAN_NONE);
    cnt    = 10'h001 << (n - flash_protect_pkg::SPAN_ONE);
    if (all_c)
      base_c = 1'b1;
    else if (none_c)
      base_c = 1'b0;
    else if (span_code[flash_protect_pkg::SPAN_LOW_BIT])
      base_c = ({1'b0, blk} < cnt);
    else
      base_c = ({1'b0, blk} >= (flash_protect_pkg::BLK_COUNT - cnt));
    hit = base_c ^ invert_span_flag;
  end

endmodule : span_range_decode

// ===== design/flash_array_write_protect.sv
// write-protect decision and lock state of the serial flash array
// assumes instructions arrive decoded, one per cycle, on core_clk
`timescale 1ns/1ns
// How it works
// - span code low bits n pick top or bottom 2^(n-1) blocks.
// - invert flag protects exactly the complement of the span range.
// - zero code protects nothing; bit3 with bit2 or bit1 protects all.
// - end blocks tracked per 4KB sector, others per 64KB block.
// - unit with persistent or volatile lock set refuses program and erase.
// - mask disables persistent lock effect without touching stored values.
// - solid mode allows persistent edits; password mode needs unlock first.
// - advanced instructions ignored while scheme select is zero.
// - 16-bit one-time mode register written only by its own instruction.
// - mode register bits 2 and 1 choose mode; both ones mean solid.
// - bit 1 cleared fixes solid mode forever.
// - bit 2 cleared fixes password mode forever.
// - write clearing both mode bits together is aborted, register unchanged.
// - advanced scheme powers up with every volatile lock set.
// - advanced scheme ignores span code and invert flag.
// - mask at zero leaves only volatile locks protecting.
module flash_array_write_protect (
  input  wire logic                   core_clk,          // 250 MHz clock
  input  wire logic                   arst_n,            // async reset
  input  wire logic [4:0]             span_code,         // span code bits
  input  wire logic                   invert_span_flag,  // invert flag
  input  wire logic                   protect_scheme_select, // 1 advanced
  input  wire logic                   write_permit_latch,    // write permit
  input  wire logic [15:0]            lock_reg_nv,       // stored otp image
  input  wire logic                   password_unlock_ok, // good password
  input  wire logic                   cmd_valid,         // instruction
  input  wire flash_protect_pkg::op_t cmd_op,            // its opcode
  input  wire logic [24:0]            cmd_addr,          // target address
  input  wire logic [15:0]            cmd_data,          // data word
  output logic                        array_commit,      // go to array
  output logic                        array_reject,      // refused write
  output logic                        cmd_applied,       // lock op done
  output logic                        cmd_ignored,       // op dropped
  output logic [15:0]                 lock_reg,          // otp register
  output logic                        password_mode,     // mode in force
  output logic                        persistent_modify_en, // edit allowed
  output logic                        persistent_lock_mask  // mask bit
);
  localparam int UNITS = flash_protect_pkg::UNITS;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [UNITS-1:0] pers_q, pers_d;
  logic [UNITS-1:0] vol_q, vol_d;
  logic [15:0]      lock_q, lock_d;
  logic             init_q, init_d;
  logic             mod_en_q, mod_en_d;
  logic             mask_q, mask_d;
  logic             pw_q, pw_d;
  logic             commit_q, commit_d;
  logic             reject_q, reject_d;
  logic             applied_q, applied_d;
  logic             ignored_q, ignored_d;

  // ------------------------------------------------------------
  // address to unit
  // ------------------------------------------------------------
  logic [8:0]       blk;
  logic [3:0]       sect;
  logic [9:0]       unit_c;
  logic [9:0]       base_c;
  logic             span_hit;
  logic             adv_hit;
  logic             prot_hit;
  logic             end_blk;
  logic [UNITS-1:0] prot_vec;
  logic [15:0]      lock_new;

  assign blk  = cmd_addr[flash_protect_pkg::BLK_LSB +:
                         flash_protect_pkg::BLK_W];
  assign sect = cmd_addr[flash_protect_pkg::SECT_LSB +:
                         flash_protect_pkg::SECT_W];

  function automatic logic [9:0] unit_of(input logic [8:0] b,
                                         input logic [3:0] s);
    if (b == flash_protect_pkg::BLK_FIRST)
      unit_of = {6'h00, s};
    else if (b == flash_protect_pkg::BLK_LAST)
      unit_of = flash_protect_pkg::TOP_UNIT_BASE + {6'h00, s};
    else
      unit_of = {1'b0, b} + flash_protect_pkg::MID_UNIT_OFS;
  endfunction : unit_of

  span_range_decode u_span (
    .span_code        (span_code),
    .invert_span_flag (invert_span_flag),
    .blk              (blk),
    .hit              (span_hit)
  );

  // ------------------------------------------------------------
  // protection decision
  // ------------------------------------------------------------
  always_comb
  begin
    prot_vec = vol_q | (pers_q & {UNITS{mask_q}});
    end_blk  = (blk == flash_protect_pkg::BLK_FIRST) |
               (blk == flash_protect_pkg::BLK_LAST);
    unit_c   = unit_of(blk, sect);
    base_c   = unit_of(blk, 4'h0);
    adv_hit  = prot_vec[unit_c];
    if ((cmd_op == flash_protect_pkg::op_erase_block) && end_blk)
    begin
      for (int i = 0; i < flash_protect_pkg::SECT_PER_BLK; i++)
        adv_hit = adv_hit | prot_vec[base_c + i[9:0]];
    end
    prot_hit = protect_scheme_select ? adv_hit : span_hit;
  end

  // ------------------------------------------------------------
  // instruction handling
  // ------------------------------------------------------------
  always_comb
  begin
    pers_d    = pers_q;
    vol_d     = vol_q;
    lock_d    = lock_q;
    mod_en_d  = mod_en_q;
    mask_d    = mask_q;
    init_d    = 1'b0;
    commit_d  = 1'b0;
    reject_d  = 1'b0;
    applied_d = 1'b0;
    ignored_d = 1'b0;
    lock_new  = lock_q;
    lock_new[flash_protect_pkg::LOCK_PASS_BIT:
             flash_protect_pkg::LOCK_SOLID_BIT] =
      lock_q[flash_protect_pkg::LOCK_PASS_BIT:
             flash_protect_pkg::LOCK_SOLID_BIT] &
      cmd_data[flash_protect_pkg::LOCK_PASS_BIT:
               flash_protect_pkg::LOCK_SOLID_BIT];
    if (init_q)
    begin
      lock_d   = lock_reg_nv;
      mod_en_d = lock_reg_nv[flash_protect_pkg::LOCK_PASS_BIT];
      if (cmd_valid)
        ignored_d = 1'b1;
    end
    else
    begin
      if (password_unlock_ok && pw_q && protect_scheme_select)
        mod_en_d = 1'b1;
      if (cmd_valid)
      begin
        unique case (cmd_op)
          flash_protect_pkg::op_prog,
          flash_protect_pkg::op_erase_sector,
          flash_protect_pkg::op_erase_block:
          begin
            if (!write_permit_latch || prot_hit)
              reject_d = 1'b1;
            else
              commit_d = 1'b1;
          end
          flash_protect_pkg::op_pers_set,
          flash_protect_pkg::op_pers_erase_all:
          begin
            if (protect_scheme_select && write_permit_latch && mod_en_q)
            begin
              if (cmd_op == flash_protect_pkg::op_pers_set)
                pers_d[unit_c] = 1'b1;
              else
                pers_d = '0;
              applied_d = 1'b1;
            end
            else
              ignored_d = 1'b1;
          end
          flash_protect_pkg::op_vol_set,
          flash_protect_pkg::op_vol_clear,
          flash_protect_pkg::op_vol_all_set,
          flash_protect_pkg::op_vol_all_clear:
          begin
            if (protect_scheme_select && write_permit_latch)
            begin
              if (cmd_op == flash_protect_pkg::op_vol_set)
                vol_d[unit_c] = 1'b1;
              else if (cmd_op == flash_protect_pkg::op_vol_clear)
                vol_d[unit_c] = 1'b0;
              else if (cmd_op == flash_protect_pkg::op_vol_all_set)
                vol_d = '1;
              else
                vol_d = '0;
              applied_d = 1'b1;
            end
            else
              ignored_d = 1'b1;
          end
          flash_protect_pkg::op_mask_write:
          begin
            if (protect_scheme_select && write_permit_latch &&
                (!pw_q || mod_en_q))
            begin
              mask_d    = cmd_data[flash_protect_pkg::MASK_DATA_BIT];
              applied_d = 1'b1;
            end
            else
              ignored_d = 1'b1;
          end
          flash_protect_pkg::op_lock_bit_clear:
          begin
            if (protect_scheme_select && write_permit_latch)
            begin
              mod_en_d  = 1'b0;
              applied_d = 1'b1;
            end
            else
              ignored_d = 1'b1;
          end
          flash_protect_pkg::op_lock_reg_write:
          begin
            if (!protect_scheme_select || !write_permit_latch)
              ignored_d = 1'b1;
            else if ((lock_q[flash_protect_pkg::LOCK_PASS_BIT:
                              flash_protect_pkg::LOCK_SOLID_BIT] !=
                      flash_protect_pkg::LOCK_UNCHOSEN) ||
                     (lock_new[flash_protect_pkg::LOCK_PASS_BIT:
                               flash_protect_pkg::LOCK_SOLID_BIT] ==
                      flash_protect_pkg::LOCK_BOTH_ZERO))
              ignored_d = 1'b1;
            else
            begin
              lock_d    = lock_new;
              applied_d = 1'b1;
              if (!lock_new[flash_protect_pkg::LOCK_PASS_BIT])
                mod_en_d = 1'b0;
            end
          end
          default:
            ignored_d = 1'b1;
        endcase
      end
    end
    pw_d = !lock_d[flash_protect_pkg::LOCK_PASS_BIT];
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pers_q    <= '0;
      vol_q     <= '1;
      lock_q    <= flash_protect_pkg::LOCK_DEFAULT;
      init_q    <= 1'b1;
      mod_en_q  <= 1'b0;
      mask_q    <= 1'b1;
      pw_q      <= 1'b0;
      commit_q  <= 1'b0;
      reject_q  <= 1'b0;
      applied_q <= 1'b0;
      ignored_q <= 1'b0;
    end
    else
    begin
      pers_q    <= pers_d;
      vol_q     <= vol_d;
      lock_q    <= lock_d;
      init_q    <= init_d;
      mod_en_q  <= mod_en_d;
      mask_q    <= mask_d;
      pw_q      <= pw_d;
      commit_q  <= commit_d;
      reject_q  <= reject_d;
      applied_q <= applied_d;
      ignored_q <= ignored_d;
    end
  end

  assign array_commit         = commit_q;
  assign array_reject         = reject_q;
  assign cmd_applied          = applied_q;
  assign cmd_ignored          = ignored_q;
  assign lock_reg             = lock_q;
  assign password_mode        = pw_q;
  assign persistent_modify_en = mod_en_q;
  assign persistent_lock_mask = mask_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic arr_op;
  assign arr_op = cmd_valid && !init_q && write_permit_latch &&
                  (cmd_op inside {flash_protect_pkg::op_prog,
                                  flash_protect_pkg::op_erase_sector});
  sequence s_basic_take;
    arr_op && !protect_scheme_select;
  endsequence

  property p_top_block;
    s_basic_take ##0 (span_code == 5'h01 && !invert_span_flag &&
      blk == flash_protect_pkg::BLK_LAST) |=> array_reject && !array_commit;
  endproperty
  a_top_block: assert property (p_top_block)
    else $error("top block not protected");

  property p_invert_zero;
    s_basic_take ##0 (span_code[3:0] == 4'h0 && invert_span_flag)
      |=> array_reject;
  endproperty
  a_invert_zero: assert property (p_invert_zero)
    else $error("inverted zero code must protect all");

  property p_zero_code;
    s_basic_take ##0 (span_code[3:0] == 4'h0 && !invert_span_flag)
      |=> array_commit;
  endproperty
  a_zero_code: assert property (p_zero_code)
    else $error("zero code must protect nothing");

  property p_vol_lock;
    arr_op && protect_scheme_select && vol_q[unit_c] |=> array_reject;
  endproperty
  a_vol_lock: assert property (p_vol_lock)
    else $error("volatile lock ignored");

  property p_mask_keeps;
    cmd_valid && cmd_op == flash_protect_pkg::op_mask_write
      |=> pers_q == $past(pers_q);
  endproperty
  a_mask_keeps: assert property (p_mask_keeps)
    else $error("mask write changed persistent locks");

  property p_basic_ignores;
    cmd_valid && !init_q && !protect_scheme_select &&
      !(cmd_op inside {flash_protect_pkg::op_prog,
        flash_protect_pkg::op_erase_sector,
        flash_protect_pkg::op_erase_block}) |=> cmd_ignored && !cmd_applied;
  endproperty
  a_basic_ignores: assert property (p_basic_ignores)
    else $error("advanced op acted on in basic scheme");

  property p_both_abort;
    cmd_valid && !init_q && cmd_op == flash_protect_pkg::op_lock_reg_write &&
      cmd_data[2:1] == 2'h0 |=> lock_reg == $past(lock_q);
  endproperty
  a_both_abort: assert property (p_both_abort)
    else $error("double mode clear not aborted");

  property p_solid_sticks;
    !init_q && !lock_q[flash_protect_pkg::LOCK_SOLID_BIT]
      |=> !lock_reg[flash_protect_pkg::LOCK_SOLID_BIT] && !password_mode;
  endproperty
  a_solid_sticks: assert property (p_solid_sticks)
    else $error("solid mode lost");

  property p_pass_sticks;
    !init_q && !lock_q[flash_protect_pkg::LOCK_PASS_BIT]
      |=> !lock_reg[flash_protect_pkg::LOCK_PASS_BIT] ##0 password_mode;
  endproperty
  a_pass_sticks: assert property (p_pass_sticks)
    else $error("password mode lost");

  property p_power_locked;
    init_q |-> &vol_q;
  endproperty
  a_power_locked: assert property (p_power_locked)
    else $error("volatile locks not all set at power up");

  property p_one_answer;
    !(array_commit && array_reject) && !(array_reject && cmd_applied);
  endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("conflicting answers");

endmodule : flash_array_write_protect

// ===== test/host_flash_ctrl.sv
// host controller model issuing instructions to the write-protect block
// assumes the block answers right after the same edge that takes a request
`timescale 1ns/1ns
module host_flash_ctrl (
  input  wire logic              core_clk,           // clock
  input  wire logic [3:0]        resp,               // answer pulses
  output flash_protect_pkg::op_t cmd_op,             // opcode
  output logic                   cmd_valid,          // request
  output logic [24:0]            cmd_addr,           // target address
  output logic [15:0]            cmd_data,           // data word
  output logic                   write_permit_latch, // write permit
  output logic                   password_unlock_ok  // unlock pulse
);
  logic pw_stored;

  // ------------------------------------------------------------
  // request tasks
  // ------------------------------------------------------------
  initial
  begin
    cmd_op = flash_protect_pkg::op_prog;
    cmd_valid = 1'b0;
    cmd_addr = 25'h0000000;
    cmd_data = 16'h0000;
    write_permit_latch = 1'b0;
    password_unlock_ok = 1'b0;
    pw_stored = 1'b0;
  end

  // released address and data lines show the inverse of the last value
  task automatic issue(input flash_protect_pkg::op_t o,
                       input logic [24:0] a, input logic [15:0] d,
                       output logic [3:0] r);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    cmd_addr <= ~a;
    cmd_data <= ~d;
    #1 r = resp;
  endtask : issue

  // latch must be set before any modifying instruction
  task automatic permit(input logic v);
    @(posedge core_clk);
    write_permit_latch <= v;
  endtask : permit

  task automatic store_password();
    pw_stored = 1'b1;
  endtask : store_password

  // unlock only succeeds once a password was stored
  task automatic unlock();
    @(posedge core_clk);
    password_unlock_ok <= pw_stored;
    @(posedge core_clk);
    password_unlock_ok <= 1'b0;
  endtask : unlock
endmodule : host_flash_ctrl

// ===== test/tb_flash_array_write_protect.sv
// self-checking bench of the array write-protect block
// assumes the host model drives the instruction port
`timescale 1ns/1ns
module tb_flash_array_write_protect;
  localparam logic [3:0] RC = 4'h8, RJ = 4'h4, AP = 4'h2, IG = 4'h1;
  logic                   core_clk = 1'b0;
  logic                   arst_n = 1'b0;
  logic [4:0]             span_code = 5'h00;
  logic                   invert_span_flag = 1'b0;
  logic                   protect_scheme_select = 1'b0;
  logic [15:0]            lock_reg_nv = 16'hffff;
  logic                   write_permit_latch, password_unlock_ok;
  logic                   cmd_valid;
  flash_protect_pkg::op_t cmd_op;
  logic [24:0]            cmd_addr;
  logic [15:0]            cmd_data, lock_reg;
  logic                   array_commit, array_reject;
  logic                   cmd_applied, cmd_ignored;
  logic                   password_mode, persistent_modify_en;
  logic                   persistent_lock_mask;
  wire logic [3:0]        resp;
  logic [3:0]             r;
  int                     err_count = 0;
  int                     comparisons = 0;
  int                     blks [8] = '{0, 1, 255, 256, 383, 384, 510, 511};

  assign resp = {array_commit, array_reject, cmd_applied, cmd_ignored};
  always #2 core_clk = ~core_clk;

  flash_array_write_protect flash_array_write_protect_inst (
    .core_clk(core_clk), .arst_n(arst_n), .span_code(span_code),
    .invert_span_flag(invert_span_flag),
    .protect_scheme_select(protect_scheme_select),
    .write_permit_latch(write_permit_latch), .lock_reg_nv(lock_reg_nv),
    .password_unlock_ok(password_unlock_ok), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .array_commit(array_commit), .array_reject(array_reject),
    .cmd_applied(cmd_applied), .cmd_ignored(cmd_ignored),
    .lock_reg(lock_reg), .password_mode(password_mode),
    .persistent_modify_en(persistent_modify_en),
    .persistent_lock_mask(persistent_lock_mask)
  );

  host_flash_ctrl host_flash_ctrl_inst (
    .core_clk(core_clk), .resp(resp), .cmd_op(cmd_op),
    .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .write_permit_latch(write_permit_latch),
    .password_unlock_ok(password_unlock_ok)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic run(input flash_protect_pkg::op_t o, input logic [24:0] a,
                     input logic [15:0] d, input logic [3:0] e);
    host_flash_ctrl_inst.issue(o, a, d, r);
    check(o.name(), {12'h000, r}, {12'h000, e});
  endtask : run

  task automatic do_reset(input logic [15:0] nv, input logic adv);
    @(posedge core_clk);
    arst_n <= 1'b0;
    lock_reg_nv <= nv;
    protect_scheme_select <= adv;
    repeat (5) @(posedge core_clk);
    check("lock_rst", lock_reg, 16'hffff);
    check("mask_rst", {15'h0, persistent_lock_mask}, 16'h1);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check("lock_init", lock_reg, nv);
    check("pw_mode", {15'h0, password_mode}, {15'h0, ~nv[2]});
    check("mod_en", {15'h0, persistent_modify_en}, {15'h0, nv[2]});
  endtask : do_reset

  function automatic logic exp_span(input logic [4:0] c, input logic inv,
                                    input int b);
    int k;
    logic p;
    if (c[3:0] == 4'h0)
      p = 1'b0;
    else if (c[3] && (c[2] || c[1]))
      p = 1'b1;
    else
    begin
      k = 1 << (int'(c[3:0]) - 1);
      p = c[4] ? (b < k) : (b >= 512 - k);
    end
    return p ^ inv;
  endfunction : exp_span

  task automatic summarize();
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    summarize();
  end

  initial
  begin
    do_reset(16'hffff, 1'b0);
    host_flash_ctrl_inst.permit(1'b1);
    for (int c = 0; c < 32; c++)
    begin
      for (int v = 0; v < 2; v++)
      begin
        @(posedge core_clk);
        span_code <= c[4:0];
        invert_span_flag <= v[0];
        foreach (blks[i])
          run(flash_protect_pkg::op_prog, {blks[i][8:0], 16'h0}, 16'h0,
              exp_span(c[4:0], v[0], blks[i]) ? RJ : RC);
      end
    end
    run(flash_protect_pkg::op_vol_all_clear, 25'h0, 16'h0, IG);
    run(flash_protect_pkg::op_lock_reg_write, 25'h0, 16'h0005, IG);
    host_flash_ctrl_inst.permit(1'b0);
    @(posedge core_clk);
    span_code <= 5'h00;
    invert_span_flag <= 1'b0;
    run(flash_protect_pkg::op_prog, 25'h0640000, 16'h0, RJ);
    do_reset(16'hffff, 1'b1);
    host_flash_ctrl_inst.permit(1'b1);
    run(flash_protect_pkg::op_prog, 25'h0640000, 16'h0, RJ);
    run(flash_protect_pkg::op_vol_all_clear, 25'h0, 16'h0, AP);
    @(posedge core_clk);
    span_code <= 5'h1f;
    run(flash_protect_pkg::op_prog, 25'h0640000, 16'h0, RC);
    run(flash_protect_pkg::op_vol_set, 25'h0003000, 16'h0, AP);
    run(flash_protect_pkg::op_prog, 25'h0003010, 16'h0, RJ);
    run(flash_protect_pkg::op_prog, 25'h0004000, 16'h0, RC);
    run(flash_protect_pkg::op_erase_block, 25'h0000000, 16'h0, RJ);
    run(flash_protect_pkg::op_vol_set, 25'h1fff000, 16'h0, AP);
    run(flash_protect_pkg::op_prog, 25'h1ffe000, 16'h0, RC);
    run(flash_protect_pkg::op_erase_sector, 25'h1fff000, 16'h0, RJ);
    run(flash_protect_pkg::op_vol_set, 25'h0079000, 16'h0, AP);
    run(flash_protect_pkg::op_prog, 25'h0070000, 16'h0, RJ);
    run(flash_protect_pkg::op_vol_clear, 25'h0070000, 16'h0, AP);
    run(flash_protect_pkg::op_prog, 25'h007c000, 16'h0, RC);
    run(flash_protect_pkg::op_pers_set, 25'h0050000, 16'h0, AP);
    run(flash_protect_pkg::op_prog, 25'h005f000, 16'h0, RJ);
    run(flash_protect_pkg::op_mask_write, 25'h0, 16'h0000, AP);
    check("mask", {15'h0, persistent_lock_mask}, 16'h0);
    run(flash_protect_pkg::op_prog, 25'h0050000, 16'h0, RC);
    run(flash_protect_pkg::op_mask_write, 25'h0, 16'h0001, AP);
    run(flash_protect_pkg::op_prog, 25'h0050000, 16'h0, RJ);
    run(flash_protect_pkg::op_pers_erase_all, 25'h0, 16'h0, AP);
    run(flash_protect_pkg::op_prog, 25'h0050000, 16'h0, RC);
    run(flash_protect_pkg::op_lock_reg_write, 25'h0, 16'hfff9, IG);
    check("lock_keep", lock_reg, 16'hffff);
    run(flash_protect_pkg::op_lock_reg_write, 25'h0, 16'h0005, AP);
    check("lock_solid", lock_reg, 16'hfffd);
    run(flash_protect_pkg::op_lock_reg_write, 25'h0, 16'hfffb, IG);
    check("pw_off", {15'h0, password_mode}, 16'h0);
    run(flash_protect_pkg::op_lock_bit_clear, 25'h0, 16'h0, AP);
    run(flash_protect_pkg::op_pers_set, 25'h0050000, 16'h0, IG);
    do_reset(16'hfffb, 1'b1);
    host_flash_ctrl_inst.permit(1'b1);
    run(flash_protect_pkg::op_pers_set, 25'h0090000, 16'h0, IG);
    run(flash_protect_pkg::op_mask_write, 25'h0, 16'h0000, IG);
    run(flash_protect_pkg::op_lock_reg_write, 25'h0, 16'hfffd, IG);
    host_flash_ctrl_inst.store_password();
    host_flash_ctrl_inst.unlock();
    run(flash_protect_pkg::op_pers_set, 25'h0090000, 16'h0, AP);
    run(flash_protect_pkg::op_vol_all_clear, 25'h0, 16'h0, AP);
    run(flash_protect_pkg::op_prog, 25'h0090000, 16'h0, RJ);
    run(flash_protect_pkg::op_prog, 25'h00a0000, 16'h0, RC);
    host_flash_ctrl_inst.permit(1'b0);
    run(flash_protect_pkg::op_vol_all_set, 25'h0, 16'h0, IG);
    run(flash_protect_pkg::op_prog, 25'h00a0000, 16'h0, RJ);
    do_reset(16'hffff, 1'b1);
    host_flash_ctrl_inst.permit(1'b1);
    run(flash_protect_pkg::op_lock_reg_write, 25'h0, 16'hfffb, AP);
    check("pw_on", {15'h0, password_mode}, 16'h1);
    check("mod_off", {15'h0, persistent_modify_en}, 16'h0);
    check("lock_pw", lock_reg, 16'hfffb);
    summarize();
  end
endmodule : tb_flash_array_write_protect
